// ==== common/spldrv_pkg.sv ====
// package: widths, reset values, crc constants and carrier types for the sink driver
package spldrv_pkg;
  // ==========================================================
  // sizes and reset values
  localparam int          SPLDRV_STAGES     = 8;
  localparam int          SPLDRV_CRC_W      = 6;
  localparam logic [7:0]  SPLDRV_CLEAR_BYTE = 8'h00;
  localparam logic [5:0]  SPLDRV_CRC_POLY   = 6'h03;
  localparam logic [5:0]  SPLDRV_CRC_INIT   = 6'h3f;
  localparam int          SPLDRV_FIFO_DEPTH = 32;

  // ==========================================================
  // carrier from the serial side to the output side
  typedef struct packed {
    logic [7:0] data;
    logic [5:0] crc;
  } spldrv_load_t;

  typedef enum logic [1:0] {
    SPLDRV_ST_RUN   = 2'b00,
    SPLDRV_ST_CLEAR = 2'b01
  } spldrv_state_t;
endpackage

// ==== dv/serial_in_parallel_out_latch_driver_tb.sv ====
// testbench: random bytes shifted, loaded, cleared; outputs checked off a queue
`timescale 1ns/1ps
`define CMP(o, e) begin checked++; if ((o) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, o, e); end end
module serial_in_parallel_out_latch_driver_tb;
  import spldrv_pkg::*;
  logic       clk = 0, reset_n = 0, den = 1, rbm = 0, chk = 0, sout, rdy;
  logic       sin, sck, lck, rcn;
  logic [7:0] oe, lvl, q[$];
  logic [5:0] crc;
  int         sel, cyc, checked, num_errors;
  spldrv_host host (.clk(clk), .serial_in(sin), .shift_clock(sck),
    .storage_load_clock(lck), .register_clear_n(rcn));
  spldrv_core dut (.clk(clk), .reset_n(reset_n), .serial_in(sin), .shift_clock(sck),
    .storage_load_clock(lck), .register_clear_n(rcn), .drain_enable_n(den),
    .readback_mode(rbm), .serial_out(sout), .sink_outputs(lvl), .sink_outputs_oe(oe),
    .crc_readback(crc), .load_ready(rdy));
  // ====
  initial forever #10 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic note(int s, logic [7:0] e);
    sel = s;
    q.push_back(e);
    chk = 1;
    host.step(1);
    chk = 0;
    host.step(1);
  endtask
  always @(posedge clk) if (chk) begin
    logic [7:0] e;
    e = q.pop_front();
    case (sel)
      0: `CMP(sout, e[0])
      1: `CMP(oe, e)
      default: `CMP(crc, e[5:0])
    endcase
  end
  // hang guard, well above the roughly 700 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] b;
    logic [15:0] h;
    logic [5:0] c;
    h = '0;
    c = SPLDRV_CRC_INIT;
    void'($urandom(32'ha823));
    repeat (10) @(posedge clk);
    #1 reset_n = 1;
    host.clear();
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      den = 1'($urandom);
      rbm = 1'($urandom);
      for (int k = 7; k >= 0; k--) begin
        host.shift_bit(b[k]);
        h = {h[14:0], b[k]};
        c = {c[4:0], 1'b0} ^ ((c[5] ^ b[k]) ? SPLDRV_CRC_POLY : 6'h00);
        note(0, {7'h00, h[7]});
      end
      host.load();
      host.step(3);
      note(1, den ? 8'h00 : b);
      note(2, rbm ? {2'h0, c} : 8'h00);
    end
    // clear after a full byte: sinks empty and crc back at its start value
    den = 0;
    rbm = 1;
    host.clear();
    host.load();
    host.step(3);
    note(1, 8'h00);
    note(2, {2'h0, SPLDRV_CRC_INIT});
    stop_test();
  end
endmodule

// ==== dv/spldrv_host.sv ====
// host model: drives serial data, shift and load strobes and the clear
`timescale 1ns/1ps
module spldrv_host (
  input  wire logic clk,
  output logic      serial_in,
  output logic      shift_clock,
  output logic      storage_load_clock,
  output logic      register_clear_n
);
  initial begin
    serial_in = 0;
    shift_clock = 0;
    storage_load_clock = 0;
    register_clear_n = 0;
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data flips after the fall so a late sample is caught
  task automatic shift_bit(logic d);
    serial_in = d;
    step(2);
    shift_clock = 1;
    step(2);
    shift_clock = 0;
    step(1);
    serial_in = ~d;
    step(2);
  endtask
  task automatic load();
    storage_load_clock = 1;
    step(2);
    storage_load_clock = 0;
    step(2);
  endtask
  task automatic clear();
    register_clear_n = 0;
    step(4);
    register_clear_n = 1;
    step(2);
  endtask
endmodule

// ==== dv/spldrv_properties.sv ====
// checker: port properties of the sink driver core
`timescale 1ns/1ps
module spldrv_checker
  import spldrv_pkg::*;
#(parameter int STAGES = 8) (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    shift_clock,
  input wire logic                    storage_load_clock,
  input wire logic                    register_clear_n,
  input wire logic                    drain_enable_n,
  input wire logic                    readback_mode,
  input wire logic                    serial_out,
  input wire logic [STAGES-1:0]       sink_outputs,
  input wire logic [STAGES-1:0]       sink_outputs_oe,
  input wire logic [SPLDRV_CRC_W-1:0] crc_readback,
  input wire logic                    load_ready
);
  // ====
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_sink_level_zero: assert property (sink_outputs == '0)
    else $error("sink level not zero");
  a_disable_forces_off: assert property (drain_enable_n [*2] |-> sink_outputs_oe == '0)
    else $error("sinks on while disabled");
  a_clear_empties_sinks: assert property (!register_clear_n [*3] |-> sink_outputs_oe == '0)
    else $error("sinks on during clear");
  a_clear_empties_serial: assert property (!register_clear_n [*2] |-> !serial_out)
    else $error("serial out set during clear");
  a_serial_on_fall: assert property ($changed(serial_out) |->
    !$past(register_clear_n) || !$past(shift_clock)) else $error("serial out moved off fall");
  a_load_to_sink: assert property ($changed(sink_outputs_oe) && !$past(drain_enable_n) &&
    !$past(drain_enable_n, 2) && $past(register_clear_n) && $past(register_clear_n, 2) |->
    $past(storage_load_clock, 4) && !$past(storage_load_clock, 5))
    else $error("sinks moved off load");
  a_crc_idle_zero: assert property (!readback_mode |=> crc_readback == '0)
    else $error("crc shown outside readback");
  a_ready_after_reset: assert property ($past(reset_n) |-> load_ready)
    else $error("load path not ready");
  c_load: cover property ($rose(storage_load_clock) && !drain_enable_n);
  c_readback: cover property (readback_mode && crc_readback != '0);
  c_clear: cover property (!register_clear_n [*3]);
endmodule
bind spldrv_core spldrv_checker #(.STAGES(STAGES)) u_chk (.clk(clk), .reset_n(reset_n),
  .shift_clock(shift_clock), .storage_load_clock(storage_load_clock),
  .register_clear_n(register_clear_n), .drain_enable_n(drain_enable_n),
  .readback_mode(readback_mode), .serial_out(serial_out), .sink_outputs(sink_outputs),
  .sink_outputs_oe(sink_outputs_oe), .crc_readback(crc_readback), .load_ready(load_ready));

// ==== rtl/spldrv_core.sv ====
// eight-channel serial-in latch driver core
//
// Notes on behaviour
// - shift clock rise shifts serial_in in
// - eight stages; serial_out shows last stage
// - storage clock rise copies all stages
// - clear low zeroes shift, storage and sink registers; crc and latched crc return to their start value
// - storage reaches outputs only while clear high
// - enable low: sinks follow latched bits
// - enable high: all sinks forced off
// - readback gives 6-bit crc of shifted data
// - serial_out changes on shift clock fall
// - latched one turns sink on
`timescale 1ns/1ps
module spldrv_core
  import spldrv_pkg::*;
#(
  parameter int STAGES = SPLDRV_STAGES,
  parameter int DEPTH  = SPLDRV_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              serial_in,
  input  wire logic              shift_clock,
  input  wire logic              storage_load_clock,
  input  wire logic              register_clear_n,
  input  wire logic              drain_enable_n,
  input  wire logic              readback_mode,
  output logic                   serial_out,
  output logic [STAGES-1:0]      sink_outputs,
  output logic [STAGES-1:0]      sink_outputs_oe,
  output logic [SPLDRV_CRC_W-1:0] crc_readback,
  output logic                   load_ready
);
  // ==========================================================
  // edge detection of the slow host strobes, sampled on clk
  // strobes are levels held at least two clk periods, so one flop of
  // history is enough; a shorter pulse can be missed entirely
  function automatic logic rose_now(
    input logic now,
    input logic was
  );
    rose_now = now && !was;
  endfunction

  logic shiftClk_reg;
  logic loadClk_reg;
  wire  shiftRise = rose_now(shift_clock, shiftClk_reg);
  wire  shiftFall = rose_now(shiftClk_reg, shift_clock);
  wire  loadRise  = rose_now(storage_load_clock, loadClk_reg);

  // ==========================================================
  // clear tracking; an unknown code falls back to clear, the safe side
  spldrv_state_t clrState_reg;
  spldrv_state_t clrState_next;

  always_comb begin
    clrState_next = clrState_reg;
    case (clrState_reg)
      SPLDRV_ST_RUN: begin
        if (!register_clear_n) begin
          clrState_next = SPLDRV_ST_CLEAR;
        end
      end
      SPLDRV_ST_CLEAR: begin
        if (register_clear_n) begin
          clrState_next = SPLDRV_ST_RUN;
        end
      end
      default: begin
        clrState_next = SPLDRV_ST_CLEAR;
      end
    endcase
  end

  // decoded from the next state so the clear acts in the same cycle as the pin
  wire clearing = (clrState_next == SPLDRV_ST_CLEAR);

  logic [STAGES-1:0]       shift_reg;
  logic [SPLDRV_CRC_W-1:0] crc_reg;
  logic                    serialOut_reg;
  logic [STAGES-1:0]       storage_reg;
  logic [STAGES-1:0]       sink_reg;
  logic [SPLDRV_CRC_W-1:0] crcOut_reg;
  logic [SPLDRV_CRC_W-1:0] crcLatched_reg;

  // ==========================================================
  // crc step: polynomial x^6+x+1, msb first; assumed, not documented
  function automatic logic [SPLDRV_CRC_W-1:0] crc_step(
    input logic [SPLDRV_CRC_W-1:0] c,
    input logic                    d
  );
    logic fb;
    fb = c[SPLDRV_CRC_W-1] ^ d;
    crc_step = {c[SPLDRV_CRC_W-2:0], 1'b0} ^ (fb ? SPLDRV_CRC_POLY : '0);
  endfunction

  // stage 0 takes the pin, every later stage takes its neighbour
  logic [STAGES-1:0] shiftNext;
  assign shiftNext[0] = serial_in;
  for (genvar g = 1; g < STAGES; g++) begin : g_stage
    assign shiftNext[g] = shift_reg[g-1];
  end
  wire [SPLDRV_CRC_W-1:0] crcNext   = crc_step(crc_reg, serial_in);

  // ==========================================================
  // serial side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftClk_reg <= 1'b0;
      loadClk_reg  <= 1'b0;
      clrState_reg <= SPLDRV_ST_CLEAR;
    end else begin
      shiftClk_reg <= shift_clock;
      loadClk_reg  <= storage_load_clock;
      clrState_reg <= clrState_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg     <= SPLDRV_CLEAR_BYTE;
      crc_reg       <= SPLDRV_CRC_INIT;
      serialOut_reg <= 1'b0;
    end else if (clearing) begin
      shift_reg     <= SPLDRV_CLEAR_BYTE;
      crc_reg       <= SPLDRV_CRC_INIT;
      serialOut_reg <= 1'b0;
    end else begin
      if (shiftRise) begin
        shift_reg <= shiftNext;
        crc_reg   <= crcNext;
      end
      // last stage leaves on the fall, giving the next device hold margin
      if (shiftFall) begin
        serialOut_reg <= shift_reg[STAGES-1];
      end
    end
  end

  // ==========================================================
  // load path through the fifo; a full fifo drops load_ready so the
  // host must pace its storage strobes, the output side drains one a cycle
  spldrv_load_t loadIn;
  spldrv_load_t loadOut;
  logic         loadOutValid;
  logic         fifoInReady;

  assign loadIn.data = shift_reg;
  assign loadIn.crc  = crc_reg;

  spldrv_fifo #(
    .WIDTH ($bits(spldrv_load_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (clearing),
    .inValid  (loadRise && !clearing),
    .inReady  (fifoInReady),
    .inData   (loadIn),
    .outValid (loadOutValid),
    .outReady (1'b1),
    .outData  (loadOut)
  );

  // ==========================================================
  // storage and output side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      storage_reg    <= SPLDRV_CLEAR_BYTE;
      crcLatched_reg <= SPLDRV_CRC_INIT;
    end else if (clearing) begin
      storage_reg    <= SPLDRV_CLEAR_BYTE;
      crcLatched_reg <= SPLDRV_CRC_INIT;
    end else if (loadOutValid) begin
      storage_reg    <= loadOut.data;
      crcLatched_reg <= loadOut.crc;
    end
  end

  // output enable high means the sink transistor conducts
  wire               sinkGate = clearing || drain_enable_n;
  logic [STAGES-1:0] sinkNext;
  for (genvar g = 0; g < STAGES; g++) begin : g_sink
    assign sinkNext[g] = sinkGate ? 1'b0 : storage_reg[g];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sink_reg   <= '0;
      crcOut_reg <= '0;
    end else begin
      sink_reg   <= sinkNext;
      crcOut_reg <= readback_mode ? crcLatched_reg : '0;
    end
  end

  logic loadReady_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadReady_reg <= 1'b0;
    end else begin
      loadReady_reg <= fifoInReady;
    end
  end

  assign serial_out      = serialOut_reg;
  assign sink_outputs    = '0;
  assign sink_outputs_oe = sink_reg;
  assign crc_readback    = crcOut_reg;
  assign load_ready      = loadReady_reg;
endmodule

// ==== rtl/spldrv_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module spldrv_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] outData_reg;
  logic             outValid_reg;

  wire full    = (count_reg == (AW+1)'(DEPTH));
  wire haveMem = (count_reg != '0);
  wire pop     = haveMem && (!outValid_reg || outReady);
  wire push    = inValid && !full;

  assign inReady  = !full;
  assign outValid = outValid_reg;
  assign outData  = outData_reg;

  // ==========================================================
  // storage; read data comes out of a register
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      count_reg    <= '0;
      outValid_reg <= 1'b0;
      outData_reg  <= '0;
    end else if (flush) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      count_reg    <= '0;
      outValid_reg <= 1'b0;
      outData_reg  <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg   <= rdPtr_reg + 1'b1;
        outData_reg <= mem[rdPtr_reg];
      end
      if (pop) begin
        outValid_reg <= 1'b1;
      end else if (outReady) begin
        outValid_reg <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
